// ==== hw/msc_pkg.sv ====
// constants for the motor startup configuration register bank
// assumes a single 20 MHz clock and a plain synchronous register port
//
// Functional notes
// - repeat field gives one to four detection passes
// - selector clear uses dedicated open-loop limit field
// - selector set uses general current limit
// - ramp enable adds q-current ramp before closed loop
// - brake bit switches active braking off or on
// - reverse select clear reuses forward current, A1, A2
// - reverse select set uses reverse A1, A2 and, with selector clear, reverse current while the motor is driven backwards
// - second register at 86h, resets zero, parity bit 31
// - limit code maps 0.125 A up to 8.0 A
package msc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int MSC_ADDR_W = 8; // register port address width
    localparam int MSC_DATA_W = 32; // register width
    localparam logic [MSC_ADDR_W-1:0] MSC_ADDR_ONE = 8'h84; // first startup register
    localparam logic [MSC_ADDR_W-1:0] MSC_ADDR_TWO = 8'h86; // second startup register
    localparam logic [MSC_DATA_W-1:0] MSC_RST_ONE = 32'h00000000; // first register reset
    localparam logic [MSC_DATA_W-1:0] MSC_RST_TWO = 32'h00000000; // second register reset
    localparam logic [MSC_DATA_W-1:0] MSC_RD_UNMAPPED = 32'h00000000; // unmapped read value

    // ****************************************
    // fields of the first register
    // ****************************************
    localparam int MSC_THR_LSB = 9; // detect current threshold, 5 bits
    localparam int MSC_THR_W = 5;
    localparam int MSC_RLS_BIT = 8; // release mode, 0 brake 1 tristate
    localparam int MSC_ADV_LSB = 6; // advance angle, 2 bits
    localparam int MSC_REP_LSB = 4; // repeat count, 2 bits
    localparam int MSC_SRC_BIT = 3; // open-loop limit source
    localparam int MSC_RAMP_BIT = 2; // q-current ramp-down enable
    localparam int MSC_BRAKE_BIT = 1; // active braking enable
    localparam int MSC_REV_BIT = 0; // reverse-drive parameter select
    localparam int MSC_PARITY_BIT = 31; // parity in both registers

    // ****************************************
    // fields of the second register
    // ****************************************
    localparam int MSC_OLL_LSB = 27; // open-loop current limit, 4 bits
    localparam int MSC_A1_LSB = 23; // acceleration coefficient A1, 4 bits
    localparam int MSC_A2_LSB = 19; // acceleration coefficient A2, 4 bits
    localparam int MSC_CODE_W = 4; // width of the 4-bit code fields

    // ****************************************
    // value scales, milliamps
    // ****************************************
    localparam int MSC_MA_W = 14; // width of a current in milliamps
    localparam logic [MSC_THR_W-1:0] MSC_THR_MAX_CODE = 5'h11; // last usable threshold
    localparam logic [MSC_MA_W-1:0] MSC_LIMIT_MA_MIN = 14'h007D; // 0.125 A
    localparam logic [MSC_MA_W-1:0] MSC_MA_8A = 14'h1F40; // 8.0 A
    localparam logic [MSC_MA_W-1:0] MSC_MA_NONE = 14'h0000; // inapplicable code
    localparam logic [2:0] MSC_PASS_BASE = 3'h1; // passes for repeat code 0

    // handoff sequencing states
    typedef enum logic [0:0] {
        MSC_HO_IDLE,
        MSC_HO_RAMP
    } msc_handoff_t;

endpackage

// ==== hw/msc_current_decode.sv ====
// current scale decoder for limit and threshold codes
// assumes combinational use; the caller registers the results
`timescale 1ns/100ps
module msc_current_decode import msc_pkg::*; (
    input wire logic [MSC_CODE_W-1:0] limit_code,
    input wire logic [MSC_THR_W-1:0] thr_code,
    output logic [MSC_MA_W-1:0] limit_ma,
    output logic [MSC_MA_W-1:0] thr_ma,
    output logic thr_valid
);

    // ****************************************
    // open-loop limit table
    // ****************************************
    // sixteen steps, not linear at the top end
    always_comb begin
        unique case (limit_code)
            4'h0: limit_ma = MSC_LIMIT_MA_MIN;
            4'h1: limit_ma = 14'h00FA;
            4'h2: limit_ma = 14'h01F4;
            4'h3: limit_ma = 14'h03E8;
            4'h4: limit_ma = 14'h05DC;
            4'h5: limit_ma = 14'h07D0;
            4'h6: limit_ma = 14'h09C4;
            4'h7: limit_ma = 14'h0BB8;
            4'h8: limit_ma = 14'h0DAC;
            4'h9: limit_ma = 14'h0FA0;
            4'hA: limit_ma = 14'h1194;
            4'hB: limit_ma = 14'h1388;
            4'hC: limit_ma = 14'h157C;
            4'hD: limit_ma = 14'h1770;
            4'hE: limit_ma = 14'h1B58;
            4'hF: limit_ma = MSC_MA_8A;
        endcase
    end

    // ****************************************
    // detection threshold table
    // ****************************************
    // codes past the last step give zero and a low valid flag
    always_comb begin
        thr_valid = 1'b1;
        case (thr_code)
            5'h00: thr_ma = 14'h00FA;
            5'h01: thr_ma = 14'h01F4;
            5'h02: thr_ma = 14'h02EE;
            5'h03: thr_ma = 14'h03E8;
            5'h04: thr_ma = 14'h04E2;
            5'h05: thr_ma = 14'h05DC;
            5'h06: thr_ma = 14'h07D0;
            5'h07: thr_ma = 14'h09C4;
            5'h08: thr_ma = 14'h0BB8;
            5'h09: thr_ma = 14'h0E53;
            5'h0A: thr_ma = 14'h0FA0;
            5'h0B: thr_ma = 14'h123B;
            5'h0C: thr_ma = 14'h1388;
            5'h0D: thr_ma = 14'h14D5;
            5'h0E: thr_ma = 14'h1770;
            5'h0F: thr_ma = 14'h1A0B;
            5'h10: thr_ma = 14'h1CA5;
            5'h11: thr_ma = MSC_MA_8A;
            default: begin
                // not applicable codes
                thr_ma = MSC_MA_NONE;
                thr_valid = 1'b0;
            end
        endcase
    end

endmodule // msc_current_decode

// ==== hw/msc_startup_regs.sv ====
// motor startup configuration register bank and its decoded controls
// assumes a synchronous register port, read data one cycle after the strobe
`timescale 1ns/100ps
module msc_startup_regs import msc_pkg::*; (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [MSC_ADDR_W-1:0] reg_addr,
    input wire logic [MSC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [MSC_DATA_W-1:0] reg_rdata,
    input wire logic [MSC_CODE_W-1:0] general_current_limit,
    input wire logic reverse_drive_active,
    input wire logic [MSC_CODE_W-1:0] rev_open_loop_limit,
    input wire logic [MSC_CODE_W-1:0] rev_acc_a1,
    input wire logic [MSC_CODE_W-1:0] rev_acc_a2,
    input wire logic handoff_request,
    input wire logic q_ramp_done,
    output logic [MSC_THR_W-1:0] detect_current_threshold,
    output logic [MSC_MA_W-1:0] detect_threshold_ma,
    output logic detect_threshold_valid,
    output logic detect_release_mode,
    output logic [1:0] detect_advance_angle,
    output logic [2:0] detect_pass_count,
    output logic [MSC_CODE_W-1:0] open_loop_limit_code,
    output logic [MSC_MA_W-1:0] open_loop_limit_ma,
    output logic [MSC_CODE_W-1:0] acc_a1_code,
    output logic [MSC_CODE_W-1:0] acc_a2_code,
    output logic q_rampdown_start,
    output logic closed_loop_enter,
    output logic active_brake_on,
    output logic parity_one,
    output logic parity_two
);

    // ****************************************
    // storage
    // ****************************************
    logic [MSC_DATA_W-1:0] startup_one_reg; // first startup register
    logic [MSC_DATA_W-1:0] startup_two_reg; // second startup register
    msc_handoff_t handoff_reg; // handoff sequencing state

    // ****************************************
    // field views
    // ****************************************
    logic limit_src; // open-loop limit source selector
    logic rev_sel; // reverse-drive parameter select
    logic ramp_en; // q-current ramp-down enable
    logic use_rev_set; // reverse set applies now
    logic [MSC_CODE_W-1:0] fwd_limit; // forward open-loop limit field
    logic [MSC_CODE_W-1:0] fwd_a1; // forward A1 field
    logic [MSC_CODE_W-1:0] fwd_a2; // forward A2 field
    logic [MSC_CODE_W-1:0] limit_code_next; // selected open-loop limit code
    logic [MSC_MA_W-1:0] limit_ma_next; // decoded limit
    logic [MSC_MA_W-1:0] thr_ma_next; // decoded threshold
    logic thr_valid_next; // threshold code usable
    logic [1:0] rep_code; // raw repeat field

    assign limit_src = startup_one_reg[MSC_SRC_BIT];
    assign rev_sel = startup_one_reg[MSC_REV_BIT];
    assign ramp_en = startup_one_reg[MSC_RAMP_BIT];
    assign rep_code = startup_one_reg[MSC_REP_LSB +: 2];
    assign fwd_limit = startup_two_reg[MSC_OLL_LSB +: MSC_CODE_W];
    assign fwd_a1 = startup_two_reg[MSC_A1_LSB +: MSC_CODE_W];
    assign fwd_a2 = startup_two_reg[MSC_A2_LSB +: MSC_CODE_W];
    // reverse set only matters while the motor is driven backwards
    assign use_rev_set = reverse_drive_active && rev_sel;

    // ****************************************
    // register writes
    // ****************************************
    // whole word stored, upper fields belong to other logic
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            startup_one_reg <= MSC_RST_ONE;
        end else if (reg_wr && reg_addr == MSC_ADDR_ONE) begin
            startup_one_reg <= reg_wdata;
        end
    end

    // second register, zero after reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            startup_two_reg <= MSC_RST_TWO;
        end else if (reg_wr && reg_addr == MSC_ADDR_TWO) begin
            startup_two_reg <= reg_wdata;
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    // data stands for exactly one cycle, zero otherwise
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= MSC_RD_UNMAPPED;
        end else if (reg_rd) begin
            if (reg_addr == MSC_ADDR_ONE) begin
                reg_rdata <= startup_one_reg;
            end else if (reg_addr == MSC_ADDR_TWO) begin
                reg_rdata <= startup_two_reg;
            end else begin
                reg_rdata <= MSC_RD_UNMAPPED; // unmapped address
            end
        end else begin
            reg_rdata <= MSC_RD_UNMAPPED;
        end
    end

    // ****************************************
    // open-loop limit source selection
    // ****************************************
    // general limit wins over both forward and reverse fields
    always_comb begin
        if (limit_src) begin
            limit_code_next = general_current_limit;
        end else if (use_rev_set) begin
            limit_code_next = rev_open_loop_limit;
        end else begin
            limit_code_next = fwd_limit;
        end
    end

    // table lookup shared by limit and threshold
    msc_current_decode u_decode (
        .limit_code(limit_code_next),
        .thr_code(startup_one_reg[MSC_THR_LSB +: MSC_THR_W]),
        .limit_ma(limit_ma_next),
        .thr_ma(thr_ma_next),
        .thr_valid(thr_valid_next)
    );

    // ****************************************
    // registered decoded controls
    // ****************************************
    // one cycle behind the register so every output is a flop
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            open_loop_limit_code <= '0;
            open_loop_limit_ma <= MSC_LIMIT_MA_MIN;
            acc_a1_code <= '0;
            acc_a2_code <= '0;
        end else begin
            open_loop_limit_code <= limit_code_next;
            open_loop_limit_ma <= limit_ma_next;
            // coefficients follow the same forward or reverse choice
            acc_a1_code <= use_rev_set ? rev_acc_a1 : fwd_a1;
            acc_a2_code <= use_rev_set ? rev_acc_a2 : fwd_a2;
        end
    end

    // detection settings
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            detect_current_threshold <= '0;
            detect_threshold_ma <= '0;
            detect_threshold_valid <= 1'b0;
            detect_release_mode <= 1'b0;
            detect_advance_angle <= '0;
            detect_pass_count <= MSC_PASS_BASE;
        end else begin
            detect_current_threshold <= startup_one_reg[MSC_THR_LSB +: MSC_THR_W];
            detect_threshold_ma <= thr_ma_next;
            detect_threshold_valid <= thr_valid_next;
            detect_release_mode <= startup_one_reg[MSC_RLS_BIT];
            detect_advance_angle <= startup_one_reg[MSC_ADV_LSB +: 2];
            // averaged passes, code 0 means a single run
            detect_pass_count <= MSC_PASS_BASE + {1'b0, rep_code};
        end
    end

    // braking and parity mirrors
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            active_brake_on <= 1'b0;
            parity_one <= 1'b0;
            parity_two <= 1'b0;
        end else begin
            active_brake_on <= startup_one_reg[MSC_BRAKE_BIT];
            parity_one <= startup_one_reg[MSC_PARITY_BIT];
            parity_two <= startup_two_reg[MSC_PARITY_BIT];
        end
    end

    // ****************************************
    // open to closed loop handoff
    // ****************************************
    // requests during a ramp are ignored; the ramp already leads to handoff
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            handoff_reg <= MSC_HO_IDLE;
            q_rampdown_start <= 1'b0;
            closed_loop_enter <= 1'b0;
        end else begin
            q_rampdown_start <= 1'b0;
            closed_loop_enter <= 1'b0;
            unique case (handoff_reg)
                MSC_HO_IDLE: begin
                    if (handoff_request && ramp_en) begin
                        // ramp current down first
                        q_rampdown_start <= 1'b1;
                        handoff_reg <= MSC_HO_RAMP;
                    end else if (handoff_request) begin
                        // no ramp, switch straight away
                        closed_loop_enter <= 1'b1;
                    end
                end
                MSC_HO_RAMP: begin
                    // wait for the current loop to report the ramp finished
                    if (q_ramp_done) begin
                        closed_loop_enter <= 1'b1;
                        handoff_reg <= MSC_HO_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    repeat_passes_a:
    assert property (detect_pass_count == MSC_PASS_BASE + {1'b0, $past(rep_code)})
        else $error("pass count does not follow repeat field");

    limit_field_a:
    assert property (!limit_src && !use_rev_set |=> open_loop_limit_code == $past(fwd_limit))
        else $error("open-loop limit not from its own field");

    limit_general_a:
    assert property (limit_src |=> open_loop_limit_code == $past(general_current_limit))
        else $error("open-loop limit not from general limit");

    ramp_first_a:
    assert property (handoff_reg == MSC_HO_IDLE && handoff_request && ramp_en
        |=> q_rampdown_start && !closed_loop_enter && handoff_reg == MSC_HO_RAMP)
        else $error("ramp not started before closed loop");

    no_ramp_a:
    assert property (handoff_reg == MSC_HO_IDLE && handoff_request && !ramp_en
        |=> closed_loop_enter && !q_rampdown_start)
        else $error("closed loop not entered without ramp");

    ramp_end_a:
    assert property (handoff_reg == MSC_HO_RAMP && !q_ramp_done |=> !closed_loop_enter)
        else $error("closed loop entered during ramp");

    brake_follow_a:
    assert property (reg_wr && reg_addr == MSC_ADDR_ONE
        |=> ##1 active_brake_on == $past(reg_wdata[MSC_BRAKE_BIT], 2))
        else $error("brake output does not follow write");

    forward_coef_a:
    assert property (!use_rev_set |=> acc_a1_code == $past(fwd_a1) && acc_a2_code == $past(fwd_a2))
        else $error("forward coefficients not used");

    reverse_coef_a:
    assert property (use_rev_set && !limit_src
        |=> acc_a1_code == $past(rev_acc_a1) && open_loop_limit_code == $past(rev_open_loop_limit))
        else $error("reverse set not used");

    two_readback_a:
    assert property (reg_wr && reg_addr == MSC_ADDR_TWO ##1 reg_rd && reg_addr == MSC_ADDR_TWO
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("second register read back wrong");

    limit_scale_a:
    assert property (open_loop_limit_code == 4'hF |-> open_loop_limit_ma == MSC_MA_8A)
        else $error("top limit code not 8 A");

    thr_invalid_a:
    assert property (detect_current_threshold > MSC_THR_MAX_CODE
        |-> !detect_threshold_valid && detect_threshold_ma == MSC_MA_NONE)
        else $error("inapplicable threshold not flagged");

    ramp_seen_c: cover property (q_rampdown_start ##[1:20] closed_loop_enter);
    rev_used_c: cover property (use_rev_set ##1 acc_a1_code == rev_acc_a1);
    thr_bad_c: cover property (!detect_threshold_valid);
    general_lim_c: cover property (limit_src ##1 open_loop_limit_code == general_current_limit);

endmodule // msc_startup_regs

// ==== tb/msc_startup_regs_test.sv ====
// self-checking bench for the motor startup configuration register bank
// assumes hw/msc_pkg.sv and the design files are compiled first
`timescale 1ns/100ps
module msc_startup_regs_test import msc_pkg::*;;
    // ****************************************
    // clock, reset, stimulus
    // ****************************************
    logic sys_clk = 1'b0; // 20 MHz system clock
    logic resetn = 1'b0; // held low four cycles
    logic [MSC_ADDR_W-1:0] reg_addr = 8'h00;
    logic [MSC_DATA_W-1:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [MSC_DATA_W-1:0] reg_rdata;
    logic [3:0] general_current_limit = 4'h0;
    logic reverse_drive_active = 1'b0;
    logic [3:0] rev_open_loop_limit = 4'h0;
    logic [3:0] rev_acc_a1 = 4'h0;
    logic [3:0] rev_acc_a2 = 4'h0;
    logic handoff_request = 1'b0;
    logic q_ramp_done = 1'b0;
    logic [4:0] det_thr;
    logic [13:0] det_ma;
    logic det_valid, det_rls, brake_on, par_one, par_two, ramp_start, cl_enter;
    logic [1:0] det_adv;
    logic [2:0] det_pass;
    logic [3:0] ol_code, a1_code, a2_code;
    logic [13:0] ol_ma;
    // ****************************************
    // bookkeeping
    // ****************************************
    int error_cnt = 0;
    int comparisons = 0;
    logic [31:0] rd_q[$]; // expected read words, oldest first
    logic [54:0] dec_q[$]; // expected decoded snapshots
    logic [1:0] ho_q[$]; // expected {ramp start, closed loop} pulses
    logic chk_req = 1'b0; // asks the watcher for a decoded snapshot
    logic rd_last, ck_last;
    logic [1:0] ho_e;
    logic [31:0] seed = 32'd88; // xorshift state
    logic [31:0] r1_m = 32'h00000000; // model of both registers
    logic [31:0] r2_m = 32'h00000000;
    logic [31:0] x;
    int thr_tab[18] = '{250, 500, 750, 1000, 1250, 1500, 2000, 2500, 3000,
                        3667, 4000, 4667, 5000, 5333, 6000, 6667, 7333, 8000};
    int lim_tab[16] = '{125, 250, 500, 1000, 1500, 2000, 2500, 3000,
                        3500, 4000, 4500, 5000, 5500, 6000, 7000, 8000};

    always #25 sys_clk = ~sys_clk;

    msc_startup_regs dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .general_current_limit(general_current_limit),
        .reverse_drive_active(reverse_drive_active), .rev_open_loop_limit(rev_open_loop_limit),
        .rev_acc_a1(rev_acc_a1), .rev_acc_a2(rev_acc_a2), .handoff_request(handoff_request),
        .q_ramp_done(q_ramp_done), .detect_current_threshold(det_thr),
        .detect_threshold_ma(det_ma), .detect_threshold_valid(det_valid),
        .detect_release_mode(det_rls), .detect_advance_angle(det_adv),
        .detect_pass_count(det_pass), .open_loop_limit_code(ol_code),
        .open_loop_limit_ma(ol_ma), .acc_a1_code(a1_code), .acc_a2_code(a2_code),
        .q_rampdown_start(ramp_start), .closed_loop_enter(cl_enter),
        .active_brake_on(brake_on), .parity_one(par_one), .parity_two(par_two));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected decoded outputs; general limit wins over the reverse set
    function automatic logic [54:0] dec_exp(input logic [31:0] r1, input logic [31:0] r2);
        logic rv;
        logic [4:0] t;
        logic [3:0] lc;
        rv = reverse_drive_active & r1[MSC_REV_BIT];
        t = r1[MSC_THR_LSB +: MSC_THR_W];
        lc = r1[MSC_SRC_BIT] ? general_current_limit : (rv ? rev_open_loop_limit : r2[30:27]);
        return {t, (t <= 5'h11) ? 14'(thr_tab[t]) : 14'h0000, t <= 5'h11, r1[8], r1[7:6],
                3'(r1[5:4]) + 3'h1, lc, 14'(lim_tab[lc]), rv ? rev_acc_a1 : r2[26:23],
                rv ? rev_acc_a2 : r2[22:19], r1[1], r1[31], r2[31]};
    endfunction

    task automatic cmp_val(input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    // ****************************************
    // one bus cycle; every strobe is set at every edge
    // ****************************************
    task automatic step(input logic w, input logic r, input logic [7:0] a,
                        input logic [31:0] d, input logic ho, input logic qd);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        handoff_request <= ho;
        q_ramp_done <= qd;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        step(1'b1, 1'b0, a, d, 1'b0, 1'b0);
        if (a == MSC_ADDR_ONE) r1_m = d;
        if (a == MSC_ADDR_TWO) r2_m = d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        step(1'b0, 1'b1, a, 32'h00000000, 1'b0, 1'b0);
    endtask

    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b0, 8'h00, 32'h00000000, 1'b0, 1'b0);
    endtask

    // snapshot of decoded outputs taken after the next edge
    // request raised once here and lowered once at the next edge
    task automatic check_dec();
        dec_q.push_back(dec_exp(r1_m, r2_m));
        chk_req <= 1'b1;
        idle(1);
        chk_req <= 1'b0;
    endtask

    // ****************************************
    // watcher: takes the oldest note when a result shows
    // ****************************************
    always @(posedge sys_clk) begin
        rd_last <= reg_rd;
        ck_last <= chk_req;
    end

    // mid-cycle sampling keeps clear of edge races
    always @(negedge sys_clk) begin
        if (resetn && rd_last && rd_q.size() > 0) cmp_val(64'(rd_q.pop_front()), 64'(reg_rdata));
        if (resetn && ck_last && dec_q.size() > 0) cmp_val(64'(dec_q.pop_front()),
            64'({det_thr, det_ma, det_valid, det_rls, det_adv, det_pass, ol_code, ol_ma,
                 a1_code, a2_code, brake_on, par_one, par_two}));
        if (resetn && (ramp_start || cl_enter)) begin
            ho_e = (ho_q.size() > 0) ? ho_q.pop_front() : 2'h0; // stray pulse never matches
            cmp_val(64'(ho_e), 64'({ramp_start, cl_enter}));
        end
    end

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        idle(1);
        rd(MSC_ADDR_TWO, 32'h00000000);
        rd(MSC_ADDR_ONE, 32'h00000000);
        rd(8'h85, 32'h00000000);
        check_dec();
        // every threshold code, the rest random, side inputs random
        for (int i = 0; i < 32; i++) begin
            x = rnd();
            wr(MSC_ADDR_ONE, {x[31:14], 5'(i), x[8:0]});
            {general_current_limit, reverse_drive_active, rev_open_loop_limit} <= x[13:5];
            {rev_acc_a1, rev_acc_a2} <= x[21:14];
            wr(8'h85, rnd());
            // read straight after the write sees the new word
            wr(MSC_ADDR_TWO, rnd());
            rd(MSC_ADDR_TWO, r2_m);
            rd(MSC_ADDR_ONE, r1_m);
            check_dec();
        end
        // handoff without ramp: two requests back to back
        wr(MSC_ADDR_ONE, 32'h00000000);
        idle(2);
        ho_q.push_back(2'h1);
        ho_q.push_back(2'h1);
        step(1'b0, 1'b0, 8'h00, 32'h00000000, 1'b1, 1'b0);
        step(1'b0, 1'b0, 8'h00, 32'h00000000, 1'b1, 1'b0);
        idle(3);
        // handoff with ramp: a repeat while ramping is ignored
        wr(MSC_ADDR_ONE, 32'h00000004);
        idle(2);
        ho_q.push_back(2'h2);
        ho_q.push_back(2'h1);
        step(1'b0, 1'b0, 8'h00, 32'h00000000, 1'b1, 1'b0);
        step(1'b0, 1'b0, 8'h00, 32'h00000000, 1'b1, 1'b0);
        step(1'b0, 1'b0, 8'h00, 32'h00000000, 1'b0, 1'b1);
        idle(3);
        // ramp done outside a handoff brings no pulse
        step(1'b0, 1'b0, 8'h00, 32'h00000000, 1'b0, 1'b1);
        idle(4);
        cmp_val(64'h0, 64'(rd_q.size() + dec_q.size() + ho_q.size()));
        end_of_test();
    end
endmodule // msc_startup_regs_test
